// ===== rtl/tdm_switch_host_port_control.sv
`timescale 1ns/1ps
module tdm_switch_host_port_control #(
  parameter int STREAMS = 8,
  parameter int DIV = tdm_host_pkg::BIT_DIV
) (
  input wire logic clock,
  input wire logic resetn,
  input tdm_host_pkg::host_bus_t host,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_rdata_oe,
  output logic transfer_ack_n_out,
  output logic transfer_ack_n_oe,
  input wire logic [STREAMS-1:0] serial_in,
  output logic [STREAMS-1:0] serial_out,
  output logic [STREAMS-1:0] serial_out_oe,
  input wire logic output_drive_enable_pin,
  output logic aux_control_serial_out
);
  logic bit_en;
  logic [2:0] bit_idx;
  logic [4:0] chan;
  logic [1:0] fbuf;
  logic [2:0] nbit;
  logic [4:0] nch;
  logic [1:0] nfbuf;
  logic [7:0] ctrl_r;
  logic [7:0] connect_mem_low [256];
  logic [7:0] connect_mem_high [256];
  logic [7:0] dm [3][256];
  logic [7:0] in_sh_r [STREAMS];
  tdm_host_pkg::host_state_t state_r;
  logic [7:0] rdata_r;
  logic [7:0] maddr;
  logic is_mem;
  logic is_ctrl;
  logic [1:0] msel;
  logic mem_slot;
  logic mem_wr;
  logic [7:0] aux_loc;

  frame_timer #(.DIV(DIV)) u_timer (
    .clock(clock),
    .resetn(resetn),
    .bit_en(bit_en),
    .bit_idx(bit_idx),
    .chan(chan),
    .frame_buf(fbuf)
  );

  function automatic logic [1:0] buf_step(input logic [1:0] b, input logic [1:0] n);
    logic [2:0] s;
    s = {1'b0, b} + {1'b0, n};
    buf_step = (s >= 3'h3) ? 2'(s - 3'h3) : s[1:0];
  endfunction : buf_step

  // ----------------------------------------
  // slot that starts at the next bit enable
  // ----------------------------------------
  assign nbit = bit_idx + 3'h1;
  assign nch = (bit_idx == 3'h7) ? chan + 5'h01 : chan;
  assign nfbuf = (bit_idx == 3'h7 && chan == 5'h1F) ? buf_step(fbuf, 2'h1) : fbuf;

  // ----------------------------------------
  // serial input into the data memory buffers
  // ----------------------------------------
  always_ff @(posedge clock)
    if (bit_en)
      for (int s = 0; s < STREAMS; s++)
      begin
        in_sh_r[s] <= {in_sh_r[s][6:0], serial_in[s]};
        if (bit_idx == 3'h7)
          dm[fbuf][{3'(s), chan}] <= {in_sh_r[s][6:0], serial_in[s]};
      end

  // ----------------------------------------
  // per-stream output path
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < STREAMS; g++)
    begin : g_out
      logic [7:0] src;
      logic [7:0] cfg;
      logic msg;
      logic drv;
      logic [1:0] rbuf;
      logic [7:0] byte_nxt;
      logic [7:0] sh_r;
      logic en_r;
      assign src = connect_mem_low[{3'(g), nch}];
      assign cfg = connect_mem_high[{3'(g), nch}];
      assign msg = ctrl_r[tdm_host_pkg::CTRL_BCAST_BIT] | cfg[tdm_host_pkg::HIGH_MSG_BIT];
      assign drv = ctrl_r[tdm_host_pkg::CTRL_BCAST_BIT] | cfg[tdm_host_pkg::HIGH_DRIVE_BIT];
      // constant delay reads the buffer filled two frames back; variable reads this frame's buffer if src is over two channels back, else last frame's
      assign rbuf = cfg[tdm_host_pkg::HIGH_CONST_BIT] ? buf_step(nfbuf, 2'h1) :
                    ({1'b0, nch} > {1'b0, src[4:0]} + 6'h02) ? nfbuf : buf_step(nfbuf, 2'h2);
      assign byte_nxt = msg ? src : dm[rbuf][src];
      always_ff @(posedge clock or negedge resetn)
        if (!resetn)
        begin
          sh_r <= 8'h00;
          en_r <= 1'b0;
        end
        else if (bit_en)
        begin
          if (nbit == 3'h0)
          begin
            sh_r <= byte_nxt;
            en_r <= drv;
          end
          else
            sh_r <= {sh_r[6:0], 1'b0};
        end
      assign serial_out[g] = sh_r[7];
      assign serial_out_oe[g] = output_drive_enable_pin & en_r;
    end
  endgenerate

  // ----------------------------------------
  // aux control serial output
  // ----------------------------------------
  assign aux_loc = {nbit, 5'(nch + 5'h01)};

  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      aux_control_serial_out <= 1'b0;
    else if (bit_en)
      aux_control_serial_out <= connect_mem_high[aux_loc][tdm_host_pkg::HIGH_AUX_BIT];

  // ----------------------------------------
  // host address decode
  // ----------------------------------------
  always_comb
  begin
    is_mem = 1'b0;
    is_ctrl = 1'b0;
    if (host.addr[tdm_host_pkg::ADDR_MEM_BIT])
      is_mem = 1'b1;
    else if (host.addr[1:0] == 2'h0)
      is_ctrl = 1'b1;
  end

  assign maddr = {ctrl_r[tdm_host_pkg::CTRL_STREAM_LSB +: 3], host.addr[4:0]};
  assign mem_slot = (state_r == tdm_host_pkg::HOST_WAIT) && !bit_en;
  assign mem_wr = mem_slot && !host.read_not_write;

  always_comb
  begin
    msel = ctrl_r[tdm_host_pkg::CTRL_MSEL_LSB +: 2];
    if (ctrl_r[tdm_host_pkg::CTRL_SPLIT_BIT])
      msel = host.read_not_write ? tdm_host_pkg::MSEL_DATA : tdm_host_pkg::MSEL_CONN_LOW;
  end

  // ----------------------------------------
  // host access sequencer
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      state_r <= tdm_host_pkg::HOST_IDLE;
    else
      case (state_r)
        tdm_host_pkg::HOST_IDLE:
          if (!host.cs_n && host.data_strobe)
            state_r <= is_mem ? tdm_host_pkg::HOST_WAIT : tdm_host_pkg::HOST_ACK;
        tdm_host_pkg::HOST_WAIT:
          if (!bit_en)
            state_r <= tdm_host_pkg::HOST_ACK;
        tdm_host_pkg::HOST_ACK:
          if (host.cs_n || !host.data_strobe)
            state_r <= tdm_host_pkg::HOST_IDLE;
        default:
          state_r <= tdm_host_pkg::HOST_IDLE;
      endcase

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      ctrl_r <= tdm_host_pkg::CTRL_RESET;
    else if (state_r == tdm_host_pkg::HOST_IDLE && !host.cs_n && host.data_strobe &&
             is_ctrl && !host.read_not_write)
      ctrl_r <= host_wdata;

  // ----------------------------------------
  // connect memory writes
  // ----------------------------------------
  always_ff @(posedge clock)
    if (mem_wr && msel == tdm_host_pkg::MSEL_CONN_LOW)
      connect_mem_low[maddr] <= host_wdata;

  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      for (int i = 0; i < 256; i++)
        connect_mem_high[i] <= tdm_host_pkg::HIGH_RESET;
    else if (mem_wr && msel == tdm_host_pkg::MSEL_CONN_HIGH)
      connect_mem_high[maddr] <= host_wdata;

  // ----------------------------------------
  // host read data
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      rdata_r <= 8'h00;
    else if (state_r == tdm_host_pkg::HOST_IDLE && !host.cs_n && host.data_strobe)
      rdata_r <= is_ctrl ? ctrl_r : 8'h00;
    else if (mem_slot)
    begin
      if (msel == tdm_host_pkg::MSEL_DATA)
        rdata_r <= dm[fbuf][maddr];
      else if (msel == tdm_host_pkg::MSEL_CONN_LOW)
        rdata_r <= connect_mem_low[maddr];
      else if (msel == tdm_host_pkg::MSEL_CONN_HIGH)
        rdata_r <= connect_mem_high[maddr];
      else
        rdata_r <= 8'h00;
    end

  // ----------------------------------------
  // host port outputs
  // ----------------------------------------
  assign host_rdata = rdata_r;
  assign host_rdata_oe = (state_r == tdm_host_pkg::HOST_ACK) && host.read_not_write && !host.cs_n;
  assign transfer_ack_n_out = 1'b0;
  assign transfer_ack_n_oe = (state_r == tdm_host_pkg::HOST_ACK);
endmodule : tdm_switch_host_port_control

// ===== inc/tdm_host_pkg.sv
package tdm_host_pkg;
  // ----------------------------------------
  // control register layout
  // ----------------------------------------
  localparam int CTRL_SPLIT_BIT = 7;
  localparam int CTRL_BCAST_BIT = 6;
  localparam int CTRL_MSEL_LSB = 3;
  localparam int CTRL_STREAM_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] MSEL_DATA = 2'h1;
  localparam logic [1:0] MSEL_CONN_LOW = 2'h2;
  localparam logic [1:0] MSEL_CONN_HIGH = 2'h3;
  // ----------------------------------------
  // connect memory high layout
  // ----------------------------------------
  localparam int HIGH_DRIVE_BIT = 0;
  localparam int HIGH_AUX_BIT = 1;
  localparam int HIGH_MSG_BIT = 2;
  localparam int HIGH_CONST_BIT = 6;
  localparam logic [7:0] HIGH_RESET = 8'h00;
  // ----------------------------------------
  // address map and timing
  // ----------------------------------------
  localparam int ADDR_MEM_BIT = 5;
  localparam int FRAME_CHANNELS = 32;
  localparam int DM_BUFFERS = 3;
  localparam int CLOCK_MHZ = 40;
  localparam int BIT_DIV = 20;
  localparam int ACK_CM_MAX_NS = 800;
  localparam int ACK_DM_MAX_NS = 1220;
  localparam int ACK_CM_MAX_CYC = (ACK_CM_MAX_NS * CLOCK_MHZ) / 1000;
  localparam int ACK_DM_MAX_CYC = (ACK_DM_MAX_NS * CLOCK_MHZ) / 1000;

  typedef struct packed {
    logic cs_n;
    logic data_strobe;
    logic read_not_write;
    logic [5:0] addr;
  } host_bus_t;

  typedef enum logic [2:0] {
    HOST_IDLE = 3'b001,
    HOST_WAIT = 3'b010,
    HOST_ACK = 3'b100
  } host_state_t;
endpackage : tdm_host_pkg

// ===== rtl/frame_timer.sv
`timescale 1ns/1ps
module frame_timer #(
  parameter int DIV = tdm_host_pkg::BIT_DIV
) (
  input wire logic clock,
  input wire logic resetn,
  output logic bit_en,
  output logic [2:0] bit_idx,
  output logic [4:0] chan,
  output logic [1:0] frame_buf
);
  logic [7:0] div_r;

  // ----------------------------------------
  // bit rate divider
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
      div_r <= 8'h00;
    else if (div_r == 8'(DIV - 1))
      div_r <= 8'h00;
    else
      div_r <= div_r + 8'h01;

  assign bit_en = (div_r == 8'(DIV - 1));

  // ----------------------------------------
  // bit, channel and buffer counters
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn)
    if (!resetn)
    begin
      bit_idx <= 3'h0;
      chan <= 5'h00;
      frame_buf <= 2'h0;
    end
    else if (bit_en)
    begin
      bit_idx <= bit_idx + 3'h1;
      if (bit_idx == 3'h7)
      begin
        chan <= chan + 5'h01;
        if (chan == 5'h1F)
          frame_buf <= (frame_buf == 2'h2) ? 2'h0 : frame_buf + 2'h1;
      end
    end
endmodule : frame_timer

// ===== bench/host_cpu_model.sv
`timescale 1ns/1ps
module host_cpu_model (
  input wire logic clock,
  input wire logic ack_n,
  input wire logic [7:0] rdata,
  output tdm_host_pkg::host_bus_t host,
  output logic [7:0] wdata
);
  initial
  begin
    host = '{cs_n: 1'b1, data_strobe: 1'b0, read_not_write: 1'b1, addr: 6'h00};
    wdata = 8'h00;
  end

  task automatic access(input logic rnw, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q,
                        output logic late);
    int n;
    @(posedge clock);
    #2;
    host = '{cs_n: 1'b0, data_strobe: 1'b1, read_not_write: rnw, addr: a};
    wdata = rnw ? ~wdata : d;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (ack_n !== 1'b0 && n < 60);
    late = (ack_n !== 1'b0);
    q = rdata;
    #2;
    host.cs_n = 1'b1;
    host.data_strobe = 1'b0;
    wdata = ~wdata;
  endtask : access
endmodule : host_cpu_model

// ===== bench/tdm_host_port_asserts.sv
`timescale 1ns/1ps
module tdm_host_port_asserts #(
  parameter int STREAMS = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input tdm_host_pkg::host_bus_t host,
  input wire logic [7:0] host_rdata,
  input wire logic host_rdata_oe,
  input wire logic transfer_ack_n_out,
  input wire logic transfer_ack_n_oe,
  input wire logic [STREAMS-1:0] serial_out_oe,
  input wire logic output_drive_enable_pin
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic req;
  assign req = !host.cs_n && host.data_strobe;
  sequence take_s;
    $rose(req);
  endsequence
  sequence ack_s;
    transfer_ack_n_oe;
  endsequence
  AST_ACK_BOUND: assert property (take_s |-> ##[1:48] ack_s) else $error("ack late");
  AST_ACK_CAUSE: assert property ($rose(transfer_ack_n_oe) |-> $past(req)) else $error("ack no request");
  AST_ACK_HOLD: assert property (ack_s and req |=> ack_s) else $error("ack dropped early");
  AST_ACK_DROP: assert property (ack_s and !req |=> !transfer_ack_n_oe) else $error("ack stuck");
  AST_ACK_LOW: assert property (transfer_ack_n_out == 1'b0) else $error("ack level");
  AST_RD_DRIVE: assert property (host_rdata_oe |-> ack_s and host.read_not_write && !host.cs_n)
    else $error("read drive");
  AST_RD_STABLE: assert property (host_rdata_oe && $past(host_rdata_oe) |-> $stable(host_rdata))
    else $error("read data moved");
  AST_ODE_OFF: assert property (!output_drive_enable_pin |-> serial_out_oe == '0) else $error("outputs driven");
endmodule : tdm_host_port_asserts

bind tdm_switch_host_port_control tdm_host_port_asserts #(.STREAMS(STREAMS)) u_chk (.clock(clock), .resetn(resetn),
  .host(host), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe), .transfer_ack_n_out(transfer_ack_n_out),
  .transfer_ack_n_oe(transfer_ack_n_oe), .serial_out_oe(serial_out_oe), .output_drive_enable_pin(output_drive_enable_pin));

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int DIV = 4;
  localparam int FRAME = 256 * DIV;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic drive_pin = 1'b0;
  logic [7:0] serial_in = 8'hFD;
  tdm_host_pkg::host_bus_t host;
  logic [7:0] wdata, rdata, sout, sout_oe;
  logic rdata_oe, ack_out, ack_oe, aux;
  wire ack_n = ack_oe ? ack_out : 1'b1;
  wire [7:0] dbus = rdata_oe ? rdata : ~rdata;
  int mismatches = 0;
  int total_checks = 0;

  tdm_switch_host_port_control #(.STREAMS(8), .DIV(DIV)) dut (.clock(clock), .resetn(resetn), .host(host),
    .host_wdata(wdata), .host_rdata(rdata), .host_rdata_oe(rdata_oe), .transfer_ack_n_out(ack_out),
    .transfer_ack_n_oe(ack_oe), .serial_in(serial_in), .serial_out(sout), .serial_out_oe(sout_oe),
    .output_drive_enable_pin(drive_pin), .aux_control_serial_out(aux));
  host_cpu_model cpu (.clock(clock), .ack_n(ack_n), .rdata(dbus), .host(host), .wdata(wdata));

  initial
  begin
    forever #12.5 clock = ~clock;
  end

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic late;
    cpu.access(1'b0, a, d, q, late);
    check("ack timeout", 8'(late), 8'h00);
  endtask : wr

  task rd(input string name, input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic late;
    cpu.access(1'b1, a, 8'h00, q, late);
    check("ack timeout", 8'(late), 8'h00);
    check(name, q, exp);
  endtask : rd

  task close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  task test_regs;
    wr(6'h1C, 8'hA5);
    rd("ctrl", 6'h00, 8'hA5);
    rd("unmapped", 6'h01, 8'h00);
    wr(6'h00, 8'h1B);
    wr(6'h3F, 8'h47);
    rd("conn high", 6'h3F, 8'h47);
    wr(6'h00, 8'h13);
    wr(6'h25, 8'h5A);
    rd("conn low", 6'h25, 8'h5A);
    wr(6'h00, 8'h0B);
    wr(6'h3F, 8'h00);
    rd("dm", 6'h3F, 8'hFF);
    wr(6'h00, 8'h93);
    wr(6'h26, 8'h3C);
    rd("split read", 6'h26, 8'hFF);
    wr(6'h00, 8'h13);
    rd("split write", 6'h26, 8'h3C);
  endtask : test_regs

  task test_outputs;
    int a, o0, o3;
    logic [7:0] pos;
    @(posedge clock);
    #2 drive_pin = 1'b1;
    wr(6'h00, 8'h40);
    repeat (FRAME) @(posedge clock);
    #2 check("bcast oe", sout_oe, 8'hFF);
    drive_pin = 1'b0;
    #1 check("pin off oe", sout_oe, 8'h00);
    @(posedge clock);
    #2 drive_pin = 1'b1;
    wr(6'h00, 8'h00);
    repeat (FRAME) @(posedge clock);
    {a, o0, o3} = '0;
    pos = 8'h00;
    repeat (FRAME)
    begin
      @(posedge clock);
      #2;
      a += aux;
      o0 += sout_oe[0];
      o3 += sout_oe[3];
      if (aux)
        pos = {dut.chan, dut.bit_idx};
    end
    check("aux bits", 8'(a), 8'(DIV));
    check("aux slot", pos, 8'hF3);
    check("oe off", 8'(o0), 8'h00);
    check("oe chan", 8'(o3), 8'(8 * DIV));
  endtask : test_outputs

  task automatic grab(output logic [7:0] b);
    int n;
    n = 0;
    b = 8'h00;
    while (sout_oe[0] === 1'b1 && n < FRAME)
    begin
      @(posedge clock);
      #2;
      n++;
    end
    while (sout_oe[0] !== 1'b1 && n < 2 * FRAME)
    begin
      @(posedge clock);
      #2;
      n++;
    end
    check("channel found", 8'(n >= 2 * FRAME), 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      b = {b[6:0], sout[0]};
      repeat (DIV) @(posedge clock);
      #2;
    end
  endtask : grab

  task test_switch;
    logic [7:0] b;
    wr(6'h00, 8'h10);
    wr(6'h25, 8'hC3);
    wr(6'h00, 8'h18);
    wr(6'h25, 8'h05);
    grab(b);
    check("message byte", b, 8'hC3);
    wr(6'h00, 8'h10);
    wr(6'h25, 8'h20);
    wr(6'h00, 8'h18);
    wr(6'h25, 8'h01);
    grab(b);
    check("switched byte", b, 8'h00);
  endtask : test_switch

  initial
  begin
    repeat (2) @(posedge clock);
    #2 resetn = 1'b1;
    repeat (4 * FRAME) @(posedge clock);
    test_regs();
    test_outputs();
    test_switch();
    close_out();
  end

  initial
  begin
    repeat (16 * FRAME) @(posedge clock);
    mismatches++;
    close_out();
  end
endmodule : testbench
